// *** common/sod_pkg.sv ***
// shared constants and types for the serial output data block
package sod_pkg;

  // register port addresses
  localparam logic [8:0] SOD_OFS_OUT_MODE = 9'h014;
  localparam logic [8:0] SOD_OFS_SER_CTRL = 9'h021;
  localparam logic [8:0] SOD_OFS_USER_IO3 = 9'h102;
  localparam logic [8:0] SOD_OFS_STATUS   = 9'h0f0;

  // values after reset
  localparam logic [7:0] SOD_RST_OUT_MODE = 8'h01;
  localparam logic [7:0] SOD_RST_SER_CTRL = 8'h30;
  localparam logic [7:0] SOD_RST_USER_IO3 = 8'h00;

  // field positions
  localparam int SOD_BIT_FMT_TWOS  = 0;
  localparam int SOD_BIT_INVERT    = 2;
  localparam int SOD_BIT_CMG_PDN   = 3;
  localparam int SOD_BIT_WIDTH12   = 1;
  localparam int SOD_BIT_FRAME2X   = 2;
  localparam int SOD_BIT_BYTEWISE  = 4;
  localparam int SOD_BIT_DDR       = 5;
  localparam int SOD_BIT_ONE_LANE  = 6;
  localparam int SOD_BIT_OVERRUN   = 0;
  localparam int SOD_BIT_PENDING   = 1;

  // word geometry, counted in bit times
  localparam logic [4:0] SOD_TOP16   = 5'h0f;
  localparam logic [4:0] SOD_TOP12   = 5'h0b;
  localparam logic [4:0] SOD_HALF16  = 5'h08;
  localparam logic [4:0] SOD_HALF12  = 5'h06;
  localparam logic [4:0] SOD_FULL16  = 5'h10;
  localparam logic [4:0] SOD_FULL12  = 5'h0c;

  // sample path widths and buffer depth
  localparam int SOD_SAMPLE_W = 14;
  localparam int SOD_WORD_W   = 16;
  localparam int SOD_FIFO_D   = 16;

  // serializer states
  typedef enum logic [0:0] {
    SOD_ST_IDLE = 1'b0,
    SOD_ST_SEND = 1'b1
  } sod_state_type;

  // decoded serialization setting
  typedef struct packed {
    logic one_lane;
    logic ddr;
    logic bytewise;
    logic frame2x;
    logic width12;
  } sod_mode_type;

  // output link pins
  typedef struct packed {
    logic       data_clock_out;
    logic       frame_clock_out;
    logic [1:0] lane;
  } sod_link_type;

endpackage

// *** logic/sod_sync.sv ***
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sod_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// *** logic/sod_fifo.sv ***
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sod_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  // storage write
  always_ff @(posedge mclk_in)
    if (push)
      mem_q[wr_q] <= in_data_in;

  // pointers and fill level
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

endmodule
`default_nettype wire

// *** logic/sod_serializer.sv ***
// serial output data block: sample capture, buffering and lane serializer
// Contract
// - default 0x30: 16-bit, 1x, DDR two-lane bytewise
// - 0x20: 16-bit, 1x, DDR two-lane bitwise
// - 0x10: 16-bit, 1x, SDR two-lane bytewise
// - 0x00: 16-bit, 1x, SDR two-lane bitwise
// - 0x34/0x24/0x14/0x04: same, but 2x frame
// - 0x40: 16-bit, one lane DDR, clock 8x
// - 0x32/0x22: 12-bit DDR two-lane, clock 3x
// - 0x12/0x02: 12-bit SDR two-lane, clock 6x
// - 0x36/0x26/0x16/0x06: 12-bit two-lane, 2x frame
// - 0x42: 12-bit one lane DDR, clock 6x
// - user io bit 3 powers down common mode
// - twos complement default, bit 0 clear offset binary
// - output mode bit 2 inverts serial stream
`timescale 1ns/10ps
`default_nettype none
module sod_serializer (
  input  wire logic                         mclk_in,
  input  wire logic                         sys_rst_in,
  input  wire logic                         sample_clk_in,
  input  wire logic [sod_pkg::SOD_SAMPLE_W-1:0] sample_in,
  output logic                              sample_ready_out,
  input  wire logic                         reg_wr_in,
  input  wire logic [8:0]                   reg_addr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  output logic      [7:0]                   reg_rdata_out,
  output sod_pkg::sod_link_type             link_out,
  output logic                              common_mode_gen_en_out
);
  import sod_pkg::*;

  // register state
  logic [7:0]  out_mode_q;
  logic [7:0]  ser_ctrl_q;
  logic [7:0]  user_io3_q;
  logic        overrun_q;
  logic [7:0]  rdata_q;

  // sample capture
  logic        sclk_s;
  logic        sclk_last_q;
  logic [SOD_SAMPLE_W-1:0] samp_s;
  logic        samp_edge;
  logic [SOD_SAMPLE_W-1:0] samp_fmt;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [SOD_SAMPLE_W-1:0] fifo_out_data;
  logic        fifo_pop;

  // serializer state
  sod_state_type state_q;
  sod_state_type state_d;
  sod_mode_type  mode_q;
  sod_mode_type  mode_set;
  logic [SOD_WORD_W-1:0] word_q;
  logic [SOD_WORD_W-1:0] word_new;
  logic [4:0]  step_q;
  logic [4:0]  step_d;
  logic        inv_q;
  sod_link_type link_q;
  sod_link_type link_d;

  // register decode
  wire sel_mode   = (reg_addr_in == SOD_OFS_OUT_MODE);
  wire sel_ctrl   = (reg_addr_in == SOD_OFS_SER_CTRL);
  wire sel_io3    = (reg_addr_in == SOD_OFS_USER_IO3);
  wire sel_stat   = (reg_addr_in == SOD_OFS_STATUS);
  wire wr_mode    = reg_wr_in && sel_mode;
  wire wr_ctrl    = reg_wr_in && sel_ctrl;
  wire wr_io3     = reg_wr_in && sel_io3;
  wire clr_ovr    = reg_wr_in && sel_stat && reg_wdata_in[SOD_BIT_OVERRUN];
  wire [7:0] stat = {6'h00, fifo_out_valid, overrun_q};

  // read mux, unmapped addresses read zero
  wire [7:0] rd_mux = sel_mode ? out_mode_q :
                      sel_ctrl ? ser_ctrl_q :
                      sel_io3  ? user_io3_q :
                      sel_stat ? stat : 8'h00;

  // control registers
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      out_mode_q <= SOD_RST_OUT_MODE;
      ser_ctrl_q <= SOD_RST_SER_CTRL;
      user_io3_q <= SOD_RST_USER_IO3;
      rdata_q    <= 8'h00;
    end
    else
    begin
      out_mode_q <= wr_mode ? reg_wdata_in : out_mode_q;
      ser_ctrl_q <= wr_ctrl ? reg_wdata_in : ser_ctrl_q;
      user_io3_q <= wr_io3 ? reg_wdata_in : user_io3_q;
      rdata_q    <= rd_mux;
    end

  assign reg_rdata_out = rdata_q;

  // common mode generator runs unless powered down
  assign common_mode_gen_en_out = ~user_io3_q[SOD_BIT_CMG_PDN];

  // sample clock and data brought into the local domain
  sod_sync #(
    .WIDTH (1)
  ) u_sync_sclk (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (sample_clk_in),
    .sync_out   (sclk_s)
  );

  sod_sync #(
    .WIDTH (SOD_SAMPLE_W)
  ) u_sync_samp (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (sample_in),
    .sync_out   (samp_s)
  );

  // rising edge of the synchronised sample clock
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      sclk_last_q <= 1'b0;
    else
      sclk_last_q <= sclk_s;

  assign samp_edge = sclk_s && !sclk_last_q;

  // offset binary flips the sign bit only
  assign samp_fmt = {samp_s[SOD_SAMPLE_W-1] ^ ~out_mode_q[SOD_BIT_FMT_TWOS],
                     samp_s[SOD_SAMPLE_W-2:0]};

  // sample lost when the buffer is full; set wins over clear
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
      overrun_q <= 1'b0;
    else
      overrun_q <= (samp_edge && !fifo_in_ready) || (overrun_q && !clr_ovr);

  sod_fifo #(
    .WIDTH (SOD_SAMPLE_W),
    .DEPTH (SOD_FIFO_D)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (samp_edge),
    .in_data_in    (samp_fmt),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_pop)
  );

  assign sample_ready_out = fifo_in_ready;

  // code decode; unlisted codes fall through the same fields
  assign mode_set.one_lane = ser_ctrl_q[SOD_BIT_ONE_LANE];
  assign mode_set.ddr      = ser_ctrl_q[SOD_BIT_DDR] |
                             ser_ctrl_q[SOD_BIT_ONE_LANE];
  assign mode_set.bytewise = ser_ctrl_q[SOD_BIT_BYTEWISE];
  assign mode_set.frame2x  = ser_ctrl_q[SOD_BIT_FRAME2X];
  assign mode_set.width12  = ser_ctrl_q[SOD_BIT_WIDTH12];

  // 16-bit words pad low bits, 12-bit words drop them
  assign word_new = mode_set.width12 ?
                    {4'h0, fifo_out_data[SOD_SAMPLE_W-1:2]} :
                    {fifo_out_data, 2'b00};

  // bit times per word and lane geometry of the latched mode
  wire [4:0] top   = mode_q.width12 ? SOD_TOP12 : SOD_TOP16;
  wire [4:0] half  = mode_q.width12 ? SOD_HALF12 : SOD_HALF16;
  wire [4:0] full  = mode_q.width12 ? SOD_FULL12 : SOD_FULL16;
  wire [4:0] bits  = mode_q.one_lane ? full : half;
  wire [5:0] steps = {bits, 1'b0};
  wire [4:0] last  = 5'(steps - 6'h01);
  wire       done  = (step_q == last);

  // bit index and the word bit each lane carries
  wire [4:0] n     = {1'b0, step_q[4:1]};
  wire [4:0] n2    = {step_q[4:1], 1'b0};
  wire       bytes = mode_q.one_lane || mode_q.bytewise;
  wire [4:0] idx0  = bytes ? 5'(top - n) : 5'(top - n2);
  wire [4:0] idx1  = bytes ? 5'(top - half - n) :
                             5'(top - 5'h01 - n2);
  wire       bit0  = word_q[idx0[3:0]];
  wire       bit1  = mode_q.one_lane ? 1'b0 : word_q[idx1[3:0]];

  // data clock: ddr toggles mid bit, sdr one period per bit
  wire dco_ddr = step_q[0] ^ step_q[1];
  wire dco_sdr = step_q[0];
  wire dco_v   = mode_q.ddr ? dco_ddr : dco_sdr;

  // frame marker: first half of word, or each half in 2x mode
  wire [5:0] st6   = {1'b0, step_q};
  wire [5:0] b6    = {1'b0, bits};
  wire [5:0] q6    = {2'b00, bits[4:1]};
  wire       fco1  = (st6 < b6);
  wire       fco2  = (st6 < q6) || ((st6 >= b6) && (st6 < 6'(b6 + q6)));
  wire       fco_v = mode_q.frame2x ? fco2 : fco1;

  // take a new word when idle or at the end of the current one
  assign fifo_pop = fifo_out_valid &&
                    ((state_q == SOD_ST_IDLE) || done);

  // next state and step
  always_comb
  begin
    state_d = state_q;
    step_d  = step_q;
    unique case (state_q)
      SOD_ST_IDLE:
      begin
        step_d = 5'h00;
        if (fifo_out_valid)
          state_d = SOD_ST_SEND;
      end
      SOD_ST_SEND:
      begin
        step_d = 5'(step_q + 5'h01);
        if (done)
        begin
          step_d  = 5'h00;
          state_d = fifo_out_valid ? SOD_ST_SEND : SOD_ST_IDLE;
        end
      end
    endcase
  end

  // link pins, stream inversion on data lanes only
  always_comb
  begin
    link_d = '0;
    if (state_q == SOD_ST_SEND)
    begin
      link_d.data_clock_out     = dco_v;
      link_d.frame_clock_out     = fco_v;
      link_d.lane[0] = bit0 ^ inv_q;
      link_d.lane[1] = bit1 ^ (inv_q & ~mode_q.one_lane);
    end
  end

  // serializer registers
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      state_q <= SOD_ST_IDLE;
      step_q  <= 5'h00;
      mode_q  <= '0;
      word_q  <= '0;
      inv_q   <= 1'b0;
      link_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      step_q  <= step_d;
      mode_q  <= fifo_pop ? mode_set : mode_q;
      word_q  <= fifo_pop ? word_new : word_q;
      inv_q   <= fifo_pop ? out_mode_q[SOD_BIT_INVERT] : inv_q;
      link_q  <= link_d;
    end

  // the control port is synchronous here, quiet use is the host's matter
  assign link_out = link_q;

endmodule
`default_nettype wire

// *** bench/sod_monitor.sv ***
// checker for the serial output data block ports
`timescale 1ns/10ps
`default_nettype none
module sod_monitor (
  input wire logic                  mclk_in,
  input wire logic                  sys_rst_in,
  input wire logic                  sample_ready_out,
  input wire logic                  reg_wr_in,
  input wire logic [8:0]            reg_addr_in,
  input wire logic [7:0]            reg_wdata_in,
  input wire logic [7:0]            reg_rdata_out,
  input wire sod_pkg::sod_link_type link_out,
  input wire logic                  common_mode_gen_en_out
);
  import sod_pkg::*;
  logic [7:0] mode_q;
  logic [5:0] cnt_q;
  logic       act_q;
  // word geometry from the mirrored setting
  wire logic       w12   = mode_q[SOD_BIT_WIDTH12];
  wire logic       one   = mode_q[SOD_BIT_ONE_LANE];
  wire logic [5:0] bits  = one ? (w12 ? 6'h0c : 6'h10) : (w12 ? 6'h06 : 6'h08);
  wire logic [5:0] last  = {bits[4:0], 1'b0} - 6'h01;
  wire logic [5:0] step  = act_q ? cnt_q : 6'h00;
  wire logic       busy  = act_q | link_out.frame_clock_out;
  wire logic       dco_x = (mode_q[SOD_BIT_DDR] | one) ? step[0] ^ step[1] : step[0];
  wire logic       fco_x = mode_q[SOD_BIT_FRAME2X] ?
                           (step < bits / 2 || (step >= bits && step < bits + bits / 2)) : step < bits;
  wire logic       mapped = reg_addr_in == SOD_OFS_OUT_MODE || reg_addr_in == SOD_OFS_SER_CTRL ||
                            reg_addr_in == SOD_OFS_USER_IO3 || reg_addr_in == SOD_OFS_STATUS;
  // mirror of the setting and step count within a word
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      mode_q <= SOD_RST_SER_CTRL;
      act_q  <= 1'b0;
      cnt_q  <= 6'h00;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == SOD_OFS_SER_CTRL)
        mode_q <= reg_wdata_in;
      if (busy)
      begin
        act_q <= step != last;
        cnt_q <= (step == last) ? 6'h00 : step + 6'h01;
      end
    end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  property p_fco; busy |-> link_out.frame_clock_out == fco_x; endproperty
  a_fco: assert property (p_fco) else $error("frame clock pattern wrong");
  property p_dco; busy |-> link_out.data_clock_out == dco_x; endproperty
  a_dco: assert property (p_dco) else $error("data clock pattern wrong");
  property p_lane; busy && one |-> link_out.lane[1] == 1'b0; endproperty
  a_lane: assert property (p_lane) else $error("second lane active");
  property p_idle; !busy |-> link_out == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("link pins not idle");
  property p_rd;
    (reg_wr_in && reg_addr_in == SOD_OFS_SER_CTRL ##1 reg_addr_in == SOD_OFS_SER_CTRL && !reg_wr_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_rd: assert property (p_rd) else $error("setting readback wrong");
  property p_unm; !mapped |=> reg_rdata_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_cmg;
    (reg_wr_in && reg_addr_in == SOD_OFS_USER_IO3 ##1 !reg_wr_in)
      |=> common_mode_gen_en_out == !$past(reg_wdata_in[SOD_BIT_CMG_PDN], 2);
  endproperty
  a_cmg: assert property (p_cmg) else $error("common mode enable wrong");
  property p_rst;
    $fell(sys_rst_in) |-> link_out == 4'h0 && reg_rdata_out == 8'h00 && sample_ready_out && common_mode_gen_en_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_one: cover property (busy && one);
  c_2x: cover property (busy && mode_q[SOD_BIT_FRAME2X]);
  c_full: cover property (!sample_ready_out);
endmodule
bind sod_serializer sod_monitor u_sod_monitor (
  .mclk_in                (mclk_in),
  .sys_rst_in             (sys_rst_in),
  .sample_ready_out       (sample_ready_out),
  .reg_wr_in              (reg_wr_in),
  .reg_addr_in            (reg_addr_in),
  .reg_wdata_in           (reg_wdata_in),
  .reg_rdata_out          (reg_rdata_out),
  .link_out               (link_out),
  .common_mode_gen_en_out (common_mode_gen_en_out)
);
`default_nettype wire

// *** bench/sod_capture.sv ***
// capture receiver model rebuilding words from the lanes
`timescale 1ns/10ps
`default_nettype none
module sod_capture (
  input  wire logic                  mclk_in,
  input  wire logic                  sys_rst_in,
  input  wire sod_pkg::sod_link_type link_in,
  input  wire logic [7:0]            mode_in,
  output var  logic [15:0]           word_out,
  output var  logic                  word_valid_out
);
  import sod_pkg::*;
  logic [5:0]  cnt_q;
  logic        act_q;
  logic [15:0] word_q;
  // bit positions for this step, listed codes only
  wire logic       w12  = mode_in[SOD_BIT_WIDTH12];
  wire logic       one  = mode_in[SOD_BIT_ONE_LANE];
  wire logic       bw   = mode_in[SOD_BIT_BYTEWISE];
  wire logic [5:0] last = one ? (w12 ? 6'h17 : 6'h1f) : (w12 ? 6'h0b : 6'h0f);
  wire logic [5:0] step = act_q ? cnt_q : 6'h00;
  wire logic       busy = act_q | link_in.frame_clock_out;
  wire logic [4:0] k    = step[5:1];
  wire logic [4:0] top  = w12 ? 5'h0b : 5'h0f;
  wire logic [4:0] p0   = (one | bw) ? top - k : top - {k[3:0], 1'b0};
  wire logic [4:0] p1   = bw ? (w12 ? 5'h05 : 5'h07) - k : top - {k[3:0], 1'b0} - 5'h01;
  // sample lanes once per bit time, hand over at word end
  always_ff @(posedge mclk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      act_q          <= 1'b0;
      cnt_q          <= 6'h00;
      word_q         <= 16'h0000;
      word_out       <= 16'h0000;
      word_valid_out <= 1'b0;
    end
    else
    begin
      word_valid_out <= busy && step == last;
      if (busy && step == last)
        word_out <= word_q;
      if (busy)
      begin
        act_q <= step != last;
        cnt_q <= (step == last) ? 6'h00 : step + 6'h01;
      end
      if (busy && !step[0])
        word_q[p0] <= link_in.lane[0];
      if (busy && !step[0] && !one)
        word_q[p1] <= link_in.lane[1];
    end
endmodule
`default_nettype wire

// *** bench/sod_serializer_bench.sv ***
// testbench for the serial output data block
`timescale 1ns/10ps
`default_nettype none
module sod_serializer_bench;
  import sod_pkg::*;
  logic         clk, rst, sclk, rdy, wr, cmg, wv, chk_data, saw_full;
  logic [13:0]  smp;
  logic [8:0]   addr;
  logic [7:0]   wd, rd_v, cfg, fmt, v;
  logic [15:0]  word;
  sod_link_type link;
  int           fails, checked;
  logic [15:0]  exp_q[$];
  localparam logic [7:0] CODES [18] = '{
    8'h30, 8'h20, 8'h10, 8'h00,
    8'h34, 8'h24, 8'h14, 8'h04, 8'h40,
    8'h32, 8'h22, 8'h12, 8'h02,
    8'h36, 8'h26, 8'h16, 8'h06, 8'h42
  };
  sod_serializer u_sod_serializer (.mclk_in(clk), .sys_rst_in(rst), .sample_clk_in(sclk),
    .sample_in(smp), .sample_ready_out(rdy), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_rdata_out(rd_v), .link_out(link), .common_mode_gen_en_out(cmg));
  sod_capture u_sod_capture (.mclk_in(clk), .sys_rst_in(rst), .link_in(link), .mode_in(cfg),
    .word_out(word), .word_valid_out(wv));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wreg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = rd_v;
  endtask
  task automatic creg(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] d;
    rreg(a, d);
    check({8'h00, d}, {8'h00, e});
  endtask
  // sample clock pulses at 125 ns, expected words queued
  task automatic send(input int n);
    logic [15:0] w;
    for (int i = 0; i < n; i++)
    begin
      smp = 14'h2a5b + 14'h1337 * i[13:0];
      w = cfg[SOD_BIT_WIDTH12] ? {4'h0, smp[13:2]} : {smp, 2'b00};
      w[cfg[SOD_BIT_WIDTH12] ? 11 : 15] ^= !fmt[SOD_BIT_FMT_TWOS];
      if (fmt[SOD_BIT_INVERT])
        w = w ^ (cfg[SOD_BIT_WIDTH12] ? 16'h0fff : 16'hffff);
      if (chk_data)
        exp_q.push_back(w);
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    for (int i = 0; i < 900 && exp_q.size() != 0; i++)
      @(posedge clk);
    check(16'(exp_q.size()), 16'h0000);
    repeat (40) @(posedge clk);
  endtask
  // every captured word against the queue while chk_data is set
  always @(posedge clk)
    if (wv && chk_data)
      check(word & (cfg[SOD_BIT_WIDTH12] ? 16'h0fff : 16'hffff), exp_q.pop_front());
  always @(posedge clk)
    if (!rst && rdy === 1'b0)
      saw_full <= 1'b1;
  initial
  begin
    #200000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end
  initial
  begin
    {rst, sclk, smp, wr, addr, wd, chk_data, saw_full} = {2'b10, 14'h0000, 1'b0, 9'h000, 8'h00, 2'b10};
    cfg = 8'h30;
    fmt = 8'h01;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    creg(SOD_OFS_OUT_MODE, SOD_RST_OUT_MODE);
    creg(SOD_OFS_SER_CTRL, 8'h30);
    creg(SOD_OFS_USER_IO3, 8'h00);
    check({15'h0000, cmg}, 16'h0001);
    wreg(SOD_OFS_USER_IO3, 8'h08);
    creg(SOD_OFS_USER_IO3, 8'h08);
    check({15'h0000, cmg}, 16'h0000);
    wreg(9'h0aa, 8'h5a);
    creg(9'h0aa, 8'h00);
    send(3);
    // settings change only while the link is idle
    foreach (CODES[j])
    begin
      cfg = CODES[j];
      wreg(SOD_OFS_SER_CTRL, cfg);
      creg(SOD_OFS_SER_CTRL, cfg);
      send(2);
    end
    fmt = 8'h04;
    wreg(SOD_OFS_OUT_MODE, fmt);
    cfg = 8'h22;
    wreg(SOD_OFS_SER_CTRL, cfg);
    send(3);
    // overfill the buffer in the slowest setting
    cfg = 8'h40;
    wreg(SOD_OFS_SER_CTRL, cfg);
    chk_data = 1'b0;
    send(40);
    rreg(SOD_OFS_STATUS, v);
    check({15'h0000, v[SOD_BIT_OVERRUN]}, 16'h0001);
    check({15'h0000, saw_full}, 16'h0001);
    for (int i = 0; i < 400 && v[SOD_BIT_PENDING] !== 1'b0; i++)
      rreg(SOD_OFS_STATUS, v);
    check({15'h0000, v[SOD_BIT_PENDING]}, 16'h0000);
    wreg(SOD_OFS_STATUS, 8'h01);
    creg(SOD_OFS_STATUS, 8'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
